// *** rtl/tif_filter.sv ***
`timescale 1ns/1ps
module tif_filter
  import tif_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff,
  // Decoded tag input
  input wire logic tag_valid,
  input wire logic [ID_W-1:0] tag_id,
  input wire logic tag_is_wieg,
  input wire logic tag_full_frame,
  input wire logic tag_grp_ok,
  // Report outputs
  output logic rpt_serial_ff,
  output logic rpt_wieg_ff,
  output logic [ID_W-1:0] rpt_id_ff,
  output logic rpt_xlat_ff,
  output logic relay_ff,
  // Reader option levels and retransmit tick pulse
  output logic sort_en_ff,
  output logic tag_init_en_ff,
  output logic [7:0] wieg_ivl_ff,
  output logic wieg_tick_ff,
  // Command response
  output logic rsp_valid_ff,
  output logic [1:0] rsp_code_ff
);

  // Configuration state
  logic [1:0] sep_ff;
  logic [1:0] val_ff;
  logic [1:0] tmo_sel_ff;
  logic xmit_all_ff;
  logic [4:0] opt_ff;
  // Validation tracking
  logic [ID_W-1:0] last_id_ff;
  logic [1:0] rep_cnt_ff;
  logic seen_ff;
  // Comparison history, entry 0 newest
  logic [ID_W-1:0] hist_ff [HIST_N];
  logic [HIST_N-1:0] hist_v_ff;
  // Timeout counter; wide enough for two minutes
  logic [33:0] tmo_cnt_ff;
  logic [31:0] sec_cnt_ff;
  logic [7:0] ivl_cnt_ff;

  // Command decode
  logic cmd_wr;
  logic [15:0] cmd;
  logic cmd_unq;
  logic cmd_val;
  logic cmd_tmo;
  logic cmd_opt;
  logic cmd_wiegivl;
  logic cmd_ok;
  logic hist_clr;
  logic tmo_expire;
  logic validated;
  logic unique_ok;
  logic same_repeat;
  logic [7:0] ivl_val;
  logic ivl_ok;
  // Decoded interval digits; bit 4 set marks a character that is not hex
  logic [4:0] nib_hi;
  logic [4:0] nib_lo;
  // Frame admitted to the filter at all
  logic tag_take;

  // Turn one ASCII hex character into a nibble; bit 4 flags a bad digit
  function automatic logic [4:0] hex_nib(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) begin
      hex_nib = {1'b0, c[3:0]};
    end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
      hex_nib = {1'b0, c[3:0] + 4'h9};
    end else begin
      hex_nib = 5'h10;
    end
  endfunction

  // Timeout length for a selection
  function automatic logic [33:0] tmo_len(input logic [1:0] s);
    case (s)
      2'h1: tmo_len = 34'(TMO_B_CYC);
      2'h2: tmo_len = 34'(TMO_C_CYC);
      default: tmo_len = 34'(TMO_A_CYC);
    endcase
  endfunction

  // Command word: bits 15:0 code; for 46NN, bits 31:16 hold the two ASCII chars
  assign cmd_wr = reg_wr && (reg_addr == REG_CMD);
  assign cmd = reg_wdata[15:0];
  assign cmd_unq = cmd[15:4] == CMD_UNQ_BASE[15:4] && cmd[3:0] <= 4'h3;
  assign cmd_val = cmd[15:4] == CMD_VAL_BASE[15:4] && cmd[3:0] <= 4'h3;
  assign cmd_tmo = cmd == CMD_TMO_A || cmd == CMD_TMO_B || cmd == CMD_TMO_C;
  assign cmd_opt = cmd >= CMD_OPT_LO && cmd <= CMD_OPT_HI;
  // Both interval digits decoded once; a zero interval is refused
  assign nib_hi = hex_nib(reg_wdata[31:24]);
  assign nib_lo = hex_nib(reg_wdata[23:16]);
  assign ivl_val = {nib_hi[3:0], nib_lo[3:0]};
  assign ivl_ok = !nib_hi[4] && !nib_lo[4] && ivl_val != 8'h00;
  assign cmd_wiegivl = cmd[15:8] == CMD_WIEG_PFX && ivl_ok;
  assign cmd_ok = cmd_unq || cmd_val || cmd_tmo || cmd_opt || cmd_wiegivl
                  || cmd == CMD_XMIT_ALL || cmd == CMD_UNQ_RST;

  // Validation: identical consecutive frames counted, saturating at 3, and compared against the setting
  // Group select off admits every frame; on, only frames meeting the criteria
  assign tag_take = tag_valid && (tag_grp_ok || !opt_ff[OPT_GRP2]);
  assign same_repeat = seen_ff && (tag_id == last_id_ff);
  assign validated = tag_take && (same_repeat ? rep_cnt_ff >= val_ff
                                              : val_ff == 2'h0);

  // Uniqueness over the k newest entries
  always_comb begin
    unique_ok = 1'b1;
    for (int i = 0; i < HIST_N; i++) begin
      if (i <= int'(sep_ff) && hist_v_ff[i] && hist_ff[i] == tag_id) begin
        unique_ok = 1'b0;
      end
    end
  end

  assign tmo_expire = tmo_cnt_ff == 34'h1;
  assign hist_clr = (cmd_wr && (cmd_tmo || cmd == CMD_UNQ_RST)) || tmo_expire;

  // Configuration registers, applied from the next tag on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sep_ff <= SEP_RST;
      val_ff <= VAL_RST;
      tmo_sel_ff <= TMO_RST;
      xmit_all_ff <= 1'b0;
      opt_ff <= OPT_RST;
      wieg_ivl_ff <= WIEG_IVL_RST;
    end else if (cmd_wr) begin
      if (cmd == CMD_XMIT_ALL) begin
        xmit_all_ff <= 1'b1;
      end else if (cmd_unq) begin
        sep_ff <= cmd[1:0];
        xmit_all_ff <= 1'b0;
      end else if (cmd_val) begin
        val_ff <= cmd[1:0];
      end else if (cmd_tmo) begin
        tmo_sel_ff <= 2'(cmd[3:0] - 4'h1);
      end else if (cmd_opt) begin
        // Even code clears, odd sets, per option pair, except initialize, where even sets and odd clears
        case (cmd[3:1])
          3'h0: opt_ff[OPT_WIEG] <= cmd[0];
          3'h1: opt_ff[OPT_XLAT] <= cmd[0];
          3'h2: opt_ff[OPT_SORT] <= cmd[0];
          3'h3: opt_ff[OPT_INIT] <= !cmd[0];
          default: opt_ff[OPT_GRP2] <= cmd[0];
        endcase
      end else if (cmd_wiegivl) begin
        wieg_ivl_ff <= ivl_val;
      end
    end
  end

  // Validation repeat tracker
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_id_ff <= '0;
      rep_cnt_ff <= 2'h0;
      seen_ff <= 1'b0;
    end else if (tag_take) begin
      last_id_ff <= tag_id;
      seen_ff <= 1'b1;
      if (!same_repeat) begin
        rep_cnt_ff <= 2'h1;
      end else if (rep_cnt_ff != 2'h3) begin
        rep_cnt_ff <= rep_cnt_ff + 2'h1;
      end
    end
  end

  // History shift; a clear in the same cycle leaves only the new ID
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hist_v_ff <= '0;
      for (int i = 0; i < HIST_N; i++) begin
        hist_ff[i] <= '0;
      end
    end else if (validated && !xmit_all_ff) begin
      hist_ff[0] <= tag_id;
      for (int i = 1; i < HIST_N; i++) begin
        hist_ff[i] <= hist_ff[i-1];
      end
      hist_v_ff <= hist_clr ? 4'h1 : {hist_v_ff[2:0], 1'b1};
    end else if (hist_clr) begin
      hist_v_ff <= '0;
    end
  end

  // Timeout: counts down, reloaded by each accepted ID; 1 marks expiry
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmo_cnt_ff <= '0;
    end else if (hist_clr && !(validated && !xmit_all_ff)) begin
      tmo_cnt_ff <= '0;
    end else if (validated && !xmit_all_ff) begin
      tmo_cnt_ff <= tmo_len(tmo_sel_ff);
    end else if (tmo_cnt_ff != 34'h0) begin
      tmo_cnt_ff <= tmo_cnt_ff - 34'h1;
    end
  end

  // Report routing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rpt_serial_ff <= 1'b0;
      rpt_wieg_ff <= 1'b0;
      rpt_id_ff <= '0;
      rpt_xlat_ff <= 1'b0;
      relay_ff <= 1'b0;
    end else begin
      rpt_serial_ff <= 1'b0;
      rpt_wieg_ff <= 1'b0;
      relay_ff <= validated;
      if (validated && (xmit_all_ff || unique_ok)) begin
        rpt_id_ff <= tag_id;
        rpt_xlat_ff <= opt_ff[OPT_XLAT] && tag_full_frame;
        if (opt_ff[OPT_WIEG]) begin
          rpt_wieg_ff <= tag_is_wieg;
        end else begin
          rpt_serial_ff <= 1'b1;
        end
      end
    end
  end

  // Option levels out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sort_en_ff <= 1'b0;
      tag_init_en_ff <= 1'b0;
    end else begin
      sort_en_ff <= opt_ff[OPT_SORT];
      tag_init_en_ff <= opt_ff[OPT_SORT] && opt_ff[OPT_INIT];
    end
  end

  // Wiegand retransmit tick each interval of seconds
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_cnt_ff <= '0;
      ivl_cnt_ff <= 8'h0;
      wieg_tick_ff <= 1'b0;
    end else begin
      wieg_tick_ff <= 1'b0;
      if (sec_cnt_ff == 32'(SEC_CYC - 1)) begin
        sec_cnt_ff <= '0;
        if (ivl_cnt_ff + 8'h1 >= wieg_ivl_ff) begin
          ivl_cnt_ff <= 8'h0;
          wieg_tick_ff <= opt_ff[OPT_WIEG];
        end else begin
          ivl_cnt_ff <= ivl_cnt_ff + 8'h1;
        end
      end else begin
        sec_cnt_ff <= sec_cnt_ff + 32'h1;
      end
    end
  end

  // Command response pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid_ff <= 1'b0;
      rsp_code_ff <= 2'h0;
    end else begin
      rsp_valid_ff <= cmd_wr;
      if (cmd_wr) begin
        rsp_code_ff <= cmd_ok ? RSP_DONE : RSP_ERR;
      end
    end
  end

  // Register reads, data one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= '0;
    end else if (reg_rd) begin
      if (reg_addr == REG_CFG) begin
        reg_rdata_ff <= 32'(sep_ff) << CF_SEP | 32'(val_ff) << CF_VAL
                        | 32'(tmo_sel_ff) << CF_TMO | 32'(xmit_all_ff) << CF_ALL
                        | 32'(opt_ff) << CF_OPT | 32'(wieg_ivl_ff) << CF_IVL;
      end else if (reg_addr == REG_STAT) begin
        reg_rdata_ff <= {26'h0, rep_cnt_ff, hist_v_ff};
      end else if (reg_addr == REG_HIST0) begin
        reg_rdata_ff <= hist_ff[0][31:0];
      end else begin
        reg_rdata_ff <= '0;
      end
    end else begin
      reg_rdata_ff <= '0;
    end
  end

  // Checks
  a_dup_suppress: assert property (@(posedge clk) disable iff (rst)
    (validated && !xmit_all_ff && hist_v_ff[0] && hist_ff[0] == tag_id)
    |=> !rpt_serial_ff && !rpt_wieg_ff)
    else $error("duplicate of newest ID was reported");
  a_all_pass: assert property (@(posedge clk) disable iff (rst)
    (validated && xmit_all_ff && !opt_ff[OPT_WIEG]) |=> rpt_serial_ff)
    else $error("transmit-all dropped an ID");
  a_hist_push: assert property (@(posedge clk) disable iff (rst)
    (validated && !xmit_all_ff) |=> hist_v_ff[0] && hist_ff[0] == $past(tag_id))
    else $error("accepted ID not stored");
  a_clear_hist: assert property (@(posedge clk) disable iff (rst)
    (hist_clr && !validated) |=> hist_v_ff == 4'h0)
    else $error("history not cleared");
  a_relay_fire: assert property (@(posedge clk) disable iff (rst)
    validated |=> relay_ff)
    else $error("relay missed a tag");
  a_wieg_only: assert property (@(posedge clk) disable iff (rst)
    (validated && opt_ff[OPT_WIEG] && !tag_is_wieg) |=> !rpt_serial_ff && !rpt_wieg_ff)
    else $error("non-Wiegand tag reported in Wiegand mode");
  a_val_drop: assert property (@(posedge clk) disable iff (rst)
    (tag_valid && !validated) |=> !rpt_serial_ff && !rpt_wieg_ff)
    else $error("unvalidated ID reported");
  a_tmo_reload: assert property (@(posedge clk) disable iff (rst)
    (validated && !xmit_all_ff) |=> tmo_cnt_ff == tmo_len($past(tmo_sel_ff)))
    else $error("timeout not restarted");
  a_cmd_done: assert property (@(posedge clk) disable iff (rst)
    (cmd_wr && cmd_ok) |=> rsp_valid_ff && rsp_code_ff == RSP_DONE)
    else $error("command not acknowledged");
  // Refusals, group gate, validation depth, expiry and tick gating
  a_cmd_refuse: assert property (@(posedge clk) disable iff (rst)
    (cmd_wr && !cmd_ok) |=> rsp_valid_ff && rsp_code_ff == RSP_ERR)
    else $error("refused command not answered with error");
  a_grp_drop: assert property (@(posedge clk) disable iff (rst)
    (tag_valid && opt_ff[OPT_GRP2] && !tag_grp_ok)
    |=> !relay_ff && !rpt_serial_ff && !rpt_wieg_ff)
    else $error("tag lacking group criteria was acquired");
  a_val_repeat: assert property (@(posedge clk) disable iff (rst)
    (validated && val_ff != 2'h0) |-> same_repeat)
    else $error("multi-frame validation passed a first frame");
  a_tmo_expire: assert property (@(posedge clk) disable iff (rst)
    (tmo_expire && !validated) |=> hist_v_ff == 4'h0 && tmo_cnt_ff == 34'h0)
    else $error("expired timeout left history in place");
  a_tick_mode: assert property (@(posedge clk) disable iff (rst)
    wieg_tick_ff |-> $past(opt_ff[OPT_WIEG]))
    else $error("retransmit tick outside Wiegand mode");

endmodule // tif_filter

// *** inc/tif_pkg.sv ***
package tif_pkg;
  // ID width and history depth
  localparam int ID_W = 64;
  localparam int HIST_N = 4;
  // Clock rate
  localparam longint CLK_HZ = 64'd50000000;
  // Timeout choices in seconds
  localparam longint TMO_A_S = 64'd120;
  localparam longint TMO_B_S = 64'd15;
  localparam longint TMO_C_S = 64'd30;
  localparam longint TMO_A_CYC = TMO_A_S * CLK_HZ;
  localparam longint TMO_B_CYC = TMO_B_S * CLK_HZ;
  localparam longint TMO_C_CYC = TMO_C_S * CLK_HZ;
  // One second of clock cycles for the retransmit interval
  localparam longint SEC_CYC = CLK_HZ;
  // Register offsets
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_CFG = 4'h1;
  localparam logic [3:0] REG_STAT = 4'h2;
  localparam logic [3:0] REG_HIST0 = 4'h3;
  // Command codes written to the command register (low 16 bits, BCD)
  localparam logic [15:0] CMD_XMIT_ALL = 16'h0040;
  localparam logic [15:0] CMD_UNQ_BASE = 16'h4100;
  localparam logic [15:0] CMD_VAL_BASE = 16'h4200;
  localparam logic [15:0] CMD_UNQ_RST = 16'h0440;
  localparam logic [15:0] CMD_TMO_A = 16'h0441;
  localparam logic [15:0] CMD_TMO_B = 16'h0442;
  localparam logic [15:0] CMD_TMO_C = 16'h0443;
  localparam logic [15:0] CMD_OPT_LO = 16'h0450;
  localparam logic [15:0] CMD_OPT_HI = 16'h0459;
  localparam logic [7:0] CMD_WIEG_PFX = 8'h46;
  // Reset values
  localparam logic [1:0] SEP_RST = 2'h0;
  localparam logic [1:0] VAL_RST = 2'h0;
  localparam logic [1:0] TMO_RST = 2'h0;
  localparam logic [7:0] WIEG_IVL_RST = 8'h01;
  // Option bit positions in the option vector
  localparam int OPT_WIEG = 0;
  localparam int OPT_XLAT = 1;
  localparam int OPT_SORT = 2;
  localparam int OPT_INIT = 3;
  localparam int OPT_GRP2 = 4;
  localparam logic [4:0] OPT_RST = 5'h08;
  // Config readback field positions
  localparam int CF_SEP = 0;
  localparam int CF_VAL = 2;
  localparam int CF_TMO = 4;
  localparam int CF_ALL = 6;
  localparam int CF_OPT = 8;
  localparam int CF_IVL = 16;
  // Response codes
  localparam logic [1:0] RSP_DONE = 2'h1;
  localparam logic [1:0] RSP_ERR = 2'h2;
endpackage

// *** test/tif_tag_src.sv ***
`timescale 1ns/1ps
// Upstream decoder model: hands the filter one frame per call
module tif_tag_src
  import tif_pkg::*;
(
  // Clock
  clk,
  // Frame toward the filter
  tag_valid,
  tag_id,
  tag_is_wieg,
  tag_full_frame,
  tag_grp_ok
);
  input wire logic clk;
  output logic tag_valid;
  output logic [ID_W-1:0] tag_id;
  output logic tag_is_wieg;
  output logic tag_full_frame;
  output logic tag_grp_ok;
  // Quiet lines at time zero
  initial begin
    tag_valid = 1'b0;
    tag_id = '0;
    tag_is_wieg = 1'b0;
    tag_full_frame = 1'b0;
    tag_grp_ok = 1'b0;
  end
  // Frame attributes packed as {wiegand, full frame, group ok}
  task automatic send(input logic [ID_W-1:0] id, input logic [2:0] attr);
    @(posedge clk);
    tag_valid <= 1'b1;
    tag_id <= id;
    {tag_is_wieg, tag_full_frame, tag_grp_ok} <= attr;
    @(posedge clk);
    // Idle qualifiers inverted so a stale frame can never look valid
    tag_valid <= 1'b0;
    tag_id <= ~id;
    {tag_is_wieg, tag_full_frame, tag_grp_ok} <= ~attr;
  endtask
endmodule // tif_tag_src

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import tif_pkg::*;
;
  // Attributes {wiegand, full, group} and outcomes {serial, wiegand, relay}
  localparam logic [2:0] PLN = 3'b011;
  localparam logic [2:0] WG = 3'b111;
  localparam logic [2:0] HALF = 3'b001;
  localparam logic [2:0] NOGRP = 3'b010;
  localparam logic [2:0] SER = 3'b101;
  localparam logic [2:0] RLY = 3'b001;
  localparam logic [2:0] NONE = 3'b000;
  logic clk, rst, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_ff, rd_val;
  logic tag_valid, tag_is_wieg, tag_full_frame, tag_grp_ok;
  logic [ID_W-1:0] tag_id, rpt_id_ff;
  logic rpt_serial_ff, rpt_wieg_ff, rpt_xlat_ff, relay_ff;
  logic sort_en_ff, tag_init_en_ff, wieg_tick_ff, rsp_valid_ff;
  logic [7:0] wieg_ivl_ff;
  logic [1:0] rsp_code_ff;
  logic xl_exp;
  logic [4:0] opt;
  int error_cnt, n_compared;
  tif_filter DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .tag_valid(tag_valid),
    .tag_id(tag_id), .tag_is_wieg(tag_is_wieg), .tag_full_frame(tag_full_frame),
    .tag_grp_ok(tag_grp_ok), .rpt_serial_ff(rpt_serial_ff), .rpt_wieg_ff(rpt_wieg_ff),
    .rpt_id_ff(rpt_id_ff), .rpt_xlat_ff(rpt_xlat_ff), .relay_ff(relay_ff),
    .sort_en_ff(sort_en_ff), .tag_init_en_ff(tag_init_en_ff), .wieg_ivl_ff(wieg_ivl_ff),
    .wieg_tick_ff(wieg_tick_ff), .rsp_valid_ff(rsp_valid_ff), .rsp_code_ff(rsp_code_ff));
  tif_tag_src src (.clk(clk), .tag_valid(tag_valid), .tag_id(tag_id),
    .tag_is_wieg(tag_is_wieg), .tag_full_frame(tag_full_frame), .tag_grp_ok(tag_grp_ok));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Verdict and stop
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Command write; response pulse stands one cycle only
  task automatic cmd(input logic [31:0] d, input logic [1:0] code);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= REG_CMD;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
    chk("rsp_valid", 64'(rsp_valid_ff), 64'h1);
    chk("rsp_code", 64'(rsp_code_ff), 64'(code));
  endtask
  // Register read; data sampled in the one cycle it stands
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata_ff;
  endtask
  // One frame and its report
  task automatic tag(input logic [63:0] id, input logic [2:0] attr, input logic [2:0] exp);
    src.send(id, attr);
    #1;
    chk("report", 64'({rpt_serial_ff, rpt_wieg_ff, relay_ff}), 64'(exp));
    if (exp[2] | exp[1]) chk("rpt_id", rpt_id_ff, id);
    if (exp[2]) chk("xlat", 64'(rpt_xlat_ff), 64'(xl_exp));
  endtask
  // Hang guard, far beyond the few hundred cycles used
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
  // Main sequence
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, xl_exp} = '0;
    error_cnt = 0;
    n_compared = 0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped index
    rd(REG_CFG);
    chk("cfg", 64'(rd_val), 64'h0001_0800);
    // Tag initialize only drives while sorting, and sorting is off
    chk("levels", 64'({sort_en_ff, tag_init_en_ff}), 64'h0);
    rd(4'hf);
    chk("unmapped", 64'(rd_val), 64'h0);
    // Default separation of zero: only the newest entry compared
    tag(64'h0a, PLN, SER);
    tag(64'h0a, PLN, RLY);
    tag(64'h0b, PLN, SER);
    tag(64'h0a, PLN, SER);
    // Every separation, just inside and just outside its reach
    for (int n = 0; n < 4; n++) begin
      for (int x = 0; x < 2; x++) begin
        cmd(32'(CMD_UNQ_RST), RSP_DONE);
        rd(REG_STAT);
        chk("hist_clr", 64'(rd_val[3:0]), 64'h0);
        cmd(32'(CMD_UNQ_BASE + 16'(n)), RSP_DONE);
        for (int i = 1; i <= n + 1 + x; i++) tag(64'(i), PLN, SER);
        tag(64'h1, PLN, (x == 1) ? SER : RLY);
      end
    end
    rd(REG_STAT);
    chk("hist_full", 64'(rd_val[3:0]), 64'hf);
    rd(REG_HIST0);
    chk("newest", 64'(rd_val), 64'h1);
    // Suppressed ID still displaces older entries
    cmd(32'(CMD_UNQ_RST), RSP_DONE);
    cmd(32'(CMD_UNQ_BASE + 16'h1), RSP_DONE);
    tag(64'h20, PLN, SER);
    tag(64'h21, PLN, SER);
    tag(64'h21, PLN, RLY);
    tag(64'h20, PLN, SER);
    // Transmit all, then uniqueness again
    cmd(32'(CMD_XMIT_ALL), RSP_DONE);
    tag(64'h30, PLN, SER);
    tag(64'h30, PLN, SER);
    cmd(32'(CMD_UNQ_RST), RSP_DONE);
    cmd(32'(CMD_UNQ_BASE), RSP_DONE);
    tag(64'h30, PLN, SER);
    tag(64'h30, PLN, RLY);
    // Validation: four frames, then two with an interruption
    cmd(32'(CMD_VAL_BASE + 16'h3), RSP_DONE);
    repeat (3) tag(64'h40, PLN, NONE);
    tag(64'h40, PLN, SER);
    cmd(32'(CMD_VAL_BASE + 16'h1), RSP_DONE);
    tag(64'h41, PLN, NONE);
    tag(64'h42, PLN, NONE);
    tag(64'h41, PLN, NONE);
    tag(64'h41, PLN, SER);
    cmd(32'(CMD_VAL_BASE), RSP_DONE);
    // Timeout selections clear the history
    tag(64'h50, PLN, SER);
    cmd(32'(CMD_TMO_B), RSP_DONE);
    rd(REG_STAT);
    chk("tmo_clr", 64'(rd_val[3:0]), 64'h0);
    tag(64'h50, PLN, SER);
    rd(REG_CFG);
    chk("tmo_b", 64'(rd_val[5:4]), 64'h1);
    cmd(32'(CMD_TMO_C), RSP_DONE);
    rd(REG_CFG);
    chk("tmo_c", 64'(rd_val[5:4]), 64'h2);
    cmd(32'(CMD_TMO_A), RSP_DONE);
    rd(REG_CFG);
    chk("tmo_a", 64'(rd_val[5:4]), 64'h0);
    // Every option code; downward so defaults end up restored
    opt = OPT_RST;
    for (int i = 9; i >= 0; i--) begin
      cmd(32'(CMD_OPT_LO + 16'(i)), RSP_DONE);
      opt[i / 2] = (i / 2 == OPT_INIT) ? ~i[0] : i[0];
      rd(REG_CFG);
      chk("opt", 64'(rd_val[12:8]), 64'(opt));
      chk("sort", 64'(sort_en_ff), 64'(opt[OPT_SORT]));
      // Initialize is issued only as part of a sort
      chk("init", 64'(tag_init_en_ff), 64'(opt[OPT_SORT] & opt[OPT_INIT]));
    end
    // Group select drops tags lacking the criteria, and only while on
    cmd(32'(CMD_OPT_HI), RSP_DONE);
    tag(64'h60, NOGRP, NONE);
    tag(64'h61, PLN, SER);
    cmd(32'(CMD_OPT_HI - 16'h1), RSP_DONE);
    tag(64'h62, NOGRP, SER);
    // Wiegand mode: plain tags only fire the relay
    cmd(32'(CMD_OPT_LO + 16'h1), RSP_DONE);
    tag(64'h70, PLN, RLY);
    tag(64'h71, WG, 3'b011);
    // Retransmit tick is far off; a tick this early is a fault
    chk("tick", 64'(wieg_tick_ff), 64'h0);
    cmd(32'(CMD_OPT_LO), RSP_DONE);
    tag(64'h72, WG, SER);
    // Translation of full frames only
    cmd(32'(CMD_OPT_LO + 16'h3), RSP_DONE);
    xl_exp = 1'b1;
    tag(64'h80, PLN, SER);
    xl_exp = 1'b0;
    tag(64'h81, HALF, SER);
    cmd(32'(CMD_OPT_LO + 16'h2), RSP_DONE);
    tag(64'h82, PLN, SER);
    // Retransmit interval in either letter case, bad digits refused
    cmd(32'h6646_4600, RSP_DONE);
    rd(REG_CFG);
    chk("ivl_ff", 64'(wieg_ivl_ff), 64'hff);
    cmd(32'h3130_4600, RSP_DONE);
    cmd(32'h3030_4600, RSP_ERR);
    cmd(32'h6731_4600, RSP_ERR);
    cmd(32'h0000_4104, RSP_ERR);
    rd(REG_CFG);
    chk("ivl_10", 64'(rd_val[23:16]), 64'h10);
    chk("ivl_out", 64'(wieg_ivl_ff), 64'h10);
    end_of_test();
  end
endmodule // tb_top
